// ### verilog/cefi_top.v
// Function
// - Left and right AGC noise flags latch low power until sticky register read.
// - Record core standard and auxiliary interrupt ports latch until sticky read.
// - Left and right DC measurement ready flags latch, cleared by sticky read.
// - Live bits 7 and 6 show left and right headphone overcurrent now.
// - Live bit shows headset button currently pressed.
// - Live bit shows headset inserted (one) or removed (zero).
// - Live bits show left and right DRC power above signal threshold.
// - Second live register bits 1 and 0 show playback core interrupt ports.
// - Third live register bits 6 and 5 show AGC power below noise threshold.
// - Third live register bits 4 and 3 show record core interrupt ports.
// - Third live register bits 2 and 1 show DC measurement available, no clear.
// - Control bit 7 lets headset insertion raise the interrupt output.
// - Control bit 6 lets button press raise the interrupt output.
// - Control bit 5 lets either DRC threshold crossing raise the interrupt.
// - Control bit 4 lets either AGC noise detection raise the interrupt.
// - Control bit 3 lets either headphone overcurrent raise the interrupt.
// - Control bit 2 lets either DSP core interrupt raise the interrupt.
// - Control bit 1 lets DC measurement availability raise the interrupt.
// - Pulse control zero gives one active-high pulse of two milliseconds.
// - Pulse control one repeats two millisecond pulses until a sticky read.
// - Overcurrent, button, headset and DRC events latch in sticky register two.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`include "cefi_regs.vh"

module cefi_top #(
    parameter PULSE_CYC = `CEFI_PULSE_CYC,
    parameter GAP_CYC   = `CEFI_PULSE_CYC,
    parameter CNT_W     = 17
) (
    input  wire       clk,            // 40 MHz clock
    input  wire       arst_n,         // Asynchronous reset, active low
    input  wire [7:0] addr,           // Register address
    input  wire [7:0] wdata,          // Write data
    input  wire       wr_en,          // Write strobe
    input  wire       rd_en,          // Read strobe
    output reg  [7:0] rdata,          // Read data, one cycle after rd_en
    input  wire       oc_left,        // Left headphone driver overcurrent
    input  wire       oc_right,       // Right headphone driver overcurrent
    input  wire       button_press,   // Headset button pressed
    input  wire       headset_in,     // Headset inserted
    input  wire       drc_left,       // Left DRC power above threshold
    input  wire       drc_right,      // Right DRC power above threshold
    input  wire       agc_noise_left, // Left AGC power below noise threshold
    input  wire       agc_noise_right,// Right AGC power below noise threshold
    input  wire       play_dsp_std,   // Playback core standard interrupt port
    input  wire       play_dsp_aux,   // Playback core auxiliary interrupt port
    input  wire       rec_dsp_std,    // Record core standard interrupt port
    input  wire       rec_dsp_aux,    // Record core auxiliary interrupt port
    input  wire       dc_meas_left,   // Left ADC DC measurement available
    input  wire       dc_meas_right,  // Right ADC DC measurement available
    output reg        first_interrupt_output // Active-high interrupt
);

    // ****************************************************************
    // Reset release and input synchronisers
    // ****************************************************************
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_HIGH = 2'h1;
    localparam [1:0] ST_LOW  = 2'h2;
    localparam [31:0] PULSE_LAST = PULSE_CYC - 1;
    localparam [31:0] GAP_LAST   = GAP_CYC - 1;

    reg  [1:0]  rst_q;
    wire        rst_n;
    reg  [13:0] sync1_q;
    reg  [13:0] sync2_q;
    wire [13:0] ev_raw;

    assign rst_n = rst_q[1];
    assign ev_raw = {oc_left, oc_right, button_press, headset_in,
                     drc_left, drc_right, agc_noise_left, agc_noise_right,
                     play_dsp_std, play_dsp_aux, rec_dsp_std, rec_dsp_aux,
                     dc_meas_left, dc_meas_right};

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rst_q <= 2'h0;
        else
            rst_q <= {rst_q[0], 1'b1};
    end

    // The sources sit outside this clock domain, so each passes two flops.
    // This costs two cycles of latency on every live bit and every trigger.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_q <= 14'h0000;
            sync2_q <= 14'h0000;
        end
        else
        begin
            sync1_q <= ev_raw;
            sync2_q <= sync1_q;
        end
    end

    wire s_oc_l   = sync2_q[13];
    wire s_oc_r   = sync2_q[12];
    wire s_btn    = sync2_q[11];
    wire s_hs     = sync2_q[10];
    wire s_drc_l  = sync2_q[9];
    wire s_drc_r  = sync2_q[8];
    wire s_agc_l  = sync2_q[7];
    wire s_agc_r  = sync2_q[6];
    wire s_pl_std = sync2_q[5];
    wire s_pl_aux = sync2_q[4];
    wire s_rc_std = sync2_q[3];
    wire s_rc_aux = sync2_q[2];
    wire s_dc_l   = sync2_q[1];
    wire s_dc_r   = sync2_q[0];

    // ****************************************************************
    // Live flag registers
    // ****************************************************************
    wire [7:0] live_two;
    wire [7:0] live_three;

    assign live_two[`CEFI_F2_OC_LEFT]   = s_oc_l;
    assign live_two[`CEFI_F2_OC_RIGHT]  = s_oc_r;
    assign live_two[`CEFI_F2_BUTTON]    = s_btn;
    assign live_two[`CEFI_F2_HEADSET]   = s_hs;
    assign live_two[`CEFI_F2_DRC_LEFT]  = s_drc_l;
    assign live_two[`CEFI_F2_DRC_RIGHT] = s_drc_r;
    assign live_two[`CEFI_F2_PLAY_STD]  = s_pl_std;
    assign live_two[`CEFI_F2_PLAY_AUX]  = s_pl_aux;

    // Reserved bits read as zero.
    assign live_three[7]                  = 1'b0;
    assign live_three[`CEFI_F3_AGC_LEFT]  = s_agc_l;
    assign live_three[`CEFI_F3_AGC_RIGHT] = s_agc_r;
    assign live_three[`CEFI_F3_REC_STD]   = s_rc_std;
    assign live_three[`CEFI_F3_REC_AUX]   = s_rc_aux;
    assign live_three[`CEFI_F3_DC_LEFT]   = s_dc_l;
    assign live_three[`CEFI_F3_DC_RIGHT]  = s_dc_r;
    assign live_three[0]                  = 1'b0;

    // ****************************************************************
    // Register port decode
    // ****************************************************************
    // The first sticky register holds no flags in this block; its read is
    // decoded only because it stops a pulse train.
    wire rd_one   = rd_en && (addr == `CEFI_ADDR_STICKY_ONE);
    wire rd_two   = rd_en && (addr == `CEFI_ADDR_STICKY_TWO);
    wire rd_three = rd_en && (addr == `CEFI_ADDR_STICKY_THREE);
    wire stop_rd  = rd_one || rd_two || rd_three;

    reg  [7:0] ctrl_q;
    reg  [7:0] sticky2_q;
    reg  [7:0] sticky3_q;
    reg        hs_prev_q;
    reg  [7:0] rd_mux;

    always @*
    begin
        if (addr == `CEFI_ADDR_STICKY_TWO)
            rd_mux = sticky2_q;
        else if (addr == `CEFI_ADDR_STICKY_THREE)
            rd_mux = sticky3_q;
        else if (addr == `CEFI_ADDR_LIVE_TWO)
            rd_mux = live_two;
        else if (addr == `CEFI_ADDR_LIVE_THREE)
            rd_mux = live_three;
        else if (addr == `CEFI_ADDR_IRQ_CTRL)
            rd_mux = ctrl_q;
        else
            rd_mux = `CEFI_RD_UNMAPPED;
    end

    // Read data stands only in the cycle after the strobe.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= 8'h00;
        else if (rd_en)
            rdata <= rd_mux;
        else
            rdata <= 8'h00;
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_q <= `CEFI_RST_IRQ_CTRL;
        else if (wr_en && (addr == `CEFI_ADDR_IRQ_CTRL))
            ctrl_q <= wdata;
    end

    // ****************************************************************
    // Sticky flags
    // ****************************************************************
    wire       hs_change = s_hs ^ hs_prev_q;
    wire       hs_insert = s_hs & ~hs_prev_q;
    wire [7:0] set2;
    wire [7:0] set3;
    wire [7:0] sticky2_d;
    wire [7:0] sticky3_d;

    // Level sources keep their flag set while they stay high, so a read
    // clears such a flag only after its source has dropped.
    assign set2 = {s_oc_l, s_oc_r, s_btn, hs_change,
                   s_drc_l, s_drc_r, s_pl_std, s_pl_aux};
    assign set3 = {1'b0, s_agc_l, s_agc_r, s_rc_std, s_rc_aux,
                   s_dc_l, s_dc_r, 1'b0};

    // A set in the same cycle as the clearing read wins and is kept.
    assign sticky2_d = (sticky2_q & ~{8{rd_two}}) | set2;
    assign sticky3_d = (sticky3_q & ~{8{rd_three}}) | set3;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sticky2_q <= `CEFI_RST_STICKY;
            sticky3_q <= `CEFI_RST_STICKY;
            hs_prev_q <= 1'b0;
        end
        else
        begin
            sticky2_q <= sticky2_d;
            sticky3_q <= sticky3_d;
            hs_prev_q <= s_hs;
        end
    end

    // ****************************************************************
    // Interrupt trigger
    // ****************************************************************
    wire [7:0] new2 = set2 & ~sticky2_q;
    wire [7:0] new3 = set3 & ~sticky3_q;
    wire       trig;

    // Only insertion, not removal, counts as the headset interrupt event.
    assign trig =
        (ctrl_q[`CEFI_CTL_INSERT] & hs_insert) |
        (ctrl_q[`CEFI_CTL_BUTTON] & new2[`CEFI_F2_BUTTON]) |
        (ctrl_q[`CEFI_CTL_DRC] & (new2[`CEFI_F2_DRC_LEFT] |
                                  new2[`CEFI_F2_DRC_RIGHT])) |
        (ctrl_q[`CEFI_CTL_AGC] & (new3[`CEFI_F3_AGC_LEFT] |
                                  new3[`CEFI_F3_AGC_RIGHT])) |
        (ctrl_q[`CEFI_CTL_OVERCUR] & (new2[`CEFI_F2_OC_LEFT] |
                                      new2[`CEFI_F2_OC_RIGHT])) |
        (ctrl_q[`CEFI_CTL_DSP] & (new2[`CEFI_F2_PLAY_STD] |
                                  new2[`CEFI_F2_PLAY_AUX] |
                                  new3[`CEFI_F3_REC_STD] |
                                  new3[`CEFI_F3_REC_AUX])) |
        (ctrl_q[`CEFI_CTL_DCMEAS] & (new3[`CEFI_F3_DC_LEFT] |
                                     new3[`CEFI_F3_DC_RIGHT]));

    // ****************************************************************
    // Pulse generator
    // ****************************************************************
    // One counter times both the pulse and the gap, so CNT_W must hold
    // the larger of PULSE_CYC and GAP_CYC.
    reg  [1:0]       state_q;
    reg  [1:0]       state_d;
    reg  [CNT_W-1:0] cnt_q;
    reg  [CNT_W-1:0] cnt_d;
    reg              train_q;
    reg              train_d;
    wire             pulse_end = (cnt_q == PULSE_LAST[CNT_W-1:0]);
    wire             gap_end   = (cnt_q == GAP_LAST[CNT_W-1:0]);

    // A trigger in the cycle of a stopping read re-arms the train only in ST_IDLE; during a pulse or a gap the read wins.
    always @*
    begin
        train_d = train_q;
        if (trig && (state_q == ST_IDLE))
            train_d = ctrl_q[`CEFI_CTL_TRAIN];
        else if (stop_rd)
            train_d = 1'b0;
    end

    // Triggers during a pulse or a gap merge into the running output.
    // Such an event still sets its sticky flag, so the host finds it on
    // the next read even though it raised no pulse of its own.
    always @*
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            ST_IDLE:
            begin
                cnt_d = {CNT_W{1'b0}};
                if (trig)
                    state_d = ST_HIGH;
            end
            ST_HIGH:
            begin
                cnt_d = cnt_q + 1'b1;
                if (pulse_end)
                begin
                    cnt_d = {CNT_W{1'b0}};
                    if (train_d)
                        state_d = ST_LOW;
                    else
                        state_d = ST_IDLE;
                end
            end
            ST_LOW:
            begin
                cnt_d = cnt_q + 1'b1;
                if (!train_d)
                begin
                    cnt_d   = {CNT_W{1'b0}};
                    state_d = ST_IDLE;
                end
                else if (gap_end)
                begin
                    cnt_d   = {CNT_W{1'b0}};
                    state_d = ST_HIGH;
                end
            end
            default:
            begin
                cnt_d   = {CNT_W{1'b0}};
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q                <= ST_IDLE;
            cnt_q                  <= {CNT_W{1'b0}};
            train_q                <= 1'b0;
            first_interrupt_output <= 1'b0;
        end
        else
        begin
            state_q                <= state_d;
            cnt_q                  <= cnt_d;
            train_q                <= train_d;
            first_interrupt_output <= (state_d == ST_HIGH);
        end
    end

endmodule

// ### verilog/cefi_regs.vh
`ifndef CEFI_REGS_VH
`define CEFI_REGS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CEFI_ADDR_STICKY_ONE   8'h2A
`define CEFI_ADDR_STICKY_TWO   8'h2C
`define CEFI_ADDR_STICKY_THREE 8'h2D
`define CEFI_ADDR_LIVE_TWO     8'h2E
`define CEFI_ADDR_LIVE_THREE   8'h2F
`define CEFI_ADDR_IRQ_CTRL     8'h30

// ****************************************************************
// Reset values
// ****************************************************************
`define CEFI_RST_STICKY        8'h00
`define CEFI_RST_IRQ_CTRL      8'h00
`define CEFI_RD_UNMAPPED       8'h00

// ****************************************************************
// Control register fields
// ****************************************************************
`define CEFI_CTL_INSERT        7
`define CEFI_CTL_BUTTON        6
`define CEFI_CTL_DRC           5
`define CEFI_CTL_AGC           4
`define CEFI_CTL_OVERCUR       3
`define CEFI_CTL_DSP           2
`define CEFI_CTL_DCMEAS        1
`define CEFI_CTL_TRAIN         0

// ****************************************************************
// Sticky and live flag fields
// ****************************************************************
`define CEFI_F2_OC_LEFT        7
`define CEFI_F2_OC_RIGHT       6
`define CEFI_F2_BUTTON         5
`define CEFI_F2_HEADSET        4
`define CEFI_F2_DRC_LEFT       3
`define CEFI_F2_DRC_RIGHT      2
`define CEFI_F2_PLAY_STD       1
`define CEFI_F2_PLAY_AUX       0
`define CEFI_F3_AGC_LEFT       6
`define CEFI_F3_AGC_RIGHT      5
`define CEFI_F3_REC_STD        4
`define CEFI_F3_REC_AUX        3
`define CEFI_F3_DC_LEFT        2
`define CEFI_F3_DC_RIGHT       1

// ****************************************************************
// Timing
// ****************************************************************
`define CEFI_PULSE_MS          2
`define CEFI_CLK_KHZ           40000
`define CEFI_PULSE_CYC         (`CEFI_PULSE_MS * `CEFI_CLK_KHZ)

`endif

// ### sim/cefi_monitor.sv
`timescale 1ns/10ps
module cefi_monitor #(
    parameter PULSE_CYC = 8
) (
    input wire       clk,                    // Clock
    input wire       arst_n,                 // Reset, active low
    input wire [7:0] addr,                   // Address
    input wire [7:0] wdata,                  // Write data
    input wire       wr_en,                  // Write strobe
    input wire       rd_en,                  // Read strobe
    input wire [7:0] rdata,                  // Read data
    input wire       oc_left,                // Event
    input wire       oc_right,               // Event
    input wire       button_press,           // Event
    input wire       headset_in,             // Event
    input wire       drc_left,               // Event
    input wire       drc_right,              // Event
    input wire       agc_noise_left,         // Event
    input wire       agc_noise_right,        // Event
    input wire       play_dsp_std,           // Event
    input wire       play_dsp_aux,           // Event
    input wire       rec_dsp_std,            // Event
    input wire       rec_dsp_aux,            // Event
    input wire       dc_meas_left,           // Event
    input wire       dc_meas_right,          // Event
    input wire       first_interrupt_output  // Interrupt
);
    wire [13:0] ev = {oc_left, oc_right, button_press, headset_in, drc_left, drc_right,
        play_dsp_std, play_dsp_aux, agc_noise_left, agc_noise_right, rec_dsp_std,
        rec_dsp_aux, dc_meas_left, dc_meas_right};
    wire [7:0]  lv2 = ev[13:6];
    wire [7:0]  lv3 = {1'b0, ev[5:0], 1'b0};
    wire        irq = first_interrupt_output;
    reg  [13:0] e1_q;
    reg  [13:0] e2_q;
    reg  [13:0] e3_q;
    reg  [7:0]  ctl_q;
    reg  [7:0]  hcnt_q;
    // Events must be steady across the synchroniser before a read is judged.
    wire        quiet = (ev == e1_q) && (e1_q == e2_q) && (e2_q == e3_q);

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            e1_q   <= 14'h0000;
            e2_q   <= 14'h0000;
            e3_q   <= 14'h0000;
            ctl_q  <= 8'h00;
            hcnt_q <= 8'h00;
        end
        else
        begin
            e1_q   <= ev;
            e2_q   <= e1_q;
            e3_q   <= e2_q;
            ctl_q  <= (wr_en && addr == 8'h30) ? wdata : ctl_q;
            hcnt_q <= irq ? hcnt_q + 8'h01 : 8'h00;
        end
    end

    // ****************************************************************
    // Properties
    // ****************************************************************
    AST_LIVE_TWO: assert property (@(posedge clk) disable iff (!arst_n)
        rd_en && addr == 8'h2E && quiet |=> rdata == $past(lv2)) else $error("live two wrong");
    AST_LIVE_THREE: assert property (@(posedge clk) disable iff (!arst_n)
        rd_en && addr == 8'h2F && quiet |=> rdata == $past(lv3)) else $error("live three wrong");
    AST_STICKY_SET: assert property (@(posedge clk) disable iff (!arst_n)
        rd_en && addr == 8'h2D && quiet |=> (rdata & $past(lv3)) == $past(lv3))
        else $error("sticky three missing a flag");
    AST_STICKY_CLR: assert property (@(posedge clk) disable iff (!arst_n)
        rd_en && addr == 8'h2D && quiet && lv3 == 8'h00 ##1 rd_en && addr == 8'h2D
        |=> rdata == 8'h00) else $error("sticky three not cleared");
    AST_STICKY2_SET: assert property (@(posedge clk) disable iff (!arst_n)
        rd_en && addr == 8'h2C && quiet |=> (rdata & $past(lv2) & 8'hEF) == ($past(lv2) & 8'hEF))
        else $error("sticky two missing a flag");
    AST_CTRL_RW: assert property (@(posedge clk) disable iff (!arst_n)
        rd_en && addr == 8'h30 |=> rdata == $past(ctl_q)) else $error("control readback");
    AST_PULSE_LEN: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(irq) |-> hcnt_q == PULSE_CYC) else $error("pulse width wrong");
    AST_PULSE_MAX: assert property (@(posedge clk) disable iff (!arst_n)
        irq |-> hcnt_q < PULSE_CYC) else $error("pulse too long");
    AST_RISE_CAUSE: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(irq) |-> $past(ctl_q[7:1]) != 7'h00) else $error("pulse with no class enabled");
endmodule

bind cefi_top cefi_monitor #(.PULSE_CYC(PULSE_CYC)) u_mon (.clk(clk), .arst_n(arst_n),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .oc_left(oc_left), .oc_right(oc_right), .button_press(button_press),
    .headset_in(headset_in), .drc_left(drc_left), .drc_right(drc_right),
    .agc_noise_left(agc_noise_left), .agc_noise_right(agc_noise_right),
    .play_dsp_std(play_dsp_std), .play_dsp_aux(play_dsp_aux), .rec_dsp_std(rec_dsp_std),
    .rec_dsp_aux(rec_dsp_aux), .dc_meas_left(dc_meas_left), .dc_meas_right(dc_meas_right),
    .first_interrupt_output(first_interrupt_output));

// ### sim/cefi_host.sv
`timescale 1ns/10ps
module cefi_host (
    input  wire       clk,   // Clock
    output reg  [7:0] addr,  // Address
    output reg  [7:0] wdata, // Write data
    output reg        wr_en, // Write strobe
    output reg        rd_en, // Read strobe
    input  wire [7:0] rdata  // Read data
);
    initial
    begin
        addr  = 8'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end

    // ****************************************************************
    // Bus cycles
    // ****************************************************************
    // Only the control register is written, so reserved flag bits never see a write.
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        addr  <= ~a;
        wdata <= ~d;
    endtask

    task rd(input [7:0] a, output [7:0] d);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        addr  <= ~a;
        #1 d = rdata;
    endtask

    // Two reads with no gap; a sticky read is what stops a pulse train.
    task rd2(input [7:0] a, output [7:0] d1, output [7:0] d2);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        #1 d1 = rdata;
        @(posedge clk);
        rd_en <= 1'b0;
        addr  <= ~a;
        #1 d2 = rdata;
    endtask
endmodule

// ### sim/cefi_top_tb_top.sv
`timescale 1ns/10ps
module cefi_top_tb_top;
    localparam [7:0] PULSE = 8'h08;
    localparam       LIMIT = 20000;
    reg         clk;
    reg         arst_n;
    reg  [13:0] ev;
    reg  [13:0] x;
    reg  [7:0]  d;
    reg  [7:0]  d2;
    reg  [7:0]  w;
    wire [7:0]  addr;
    wire [7:0]  wdata;
    wire [7:0]  rdata;
    wire        wr_en;
    wire        rd_en;
    wire        irq;
    integer     miscompares;
    integer     check_count;
    integer     cyc;
    integer     i;
    integer     b;

    cefi_host u_host (.clk(clk), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata));

    cefi_top #(.PULSE_CYC(PULSE), .GAP_CYC(PULSE)) i_cefi_top (.clk(clk), .arst_n(arst_n),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .oc_left(ev[13]), .oc_right(ev[12]), .button_press(ev[11]), .headset_in(ev[10]),
        .drc_left(ev[9]), .drc_right(ev[8]), .play_dsp_std(ev[7]), .play_dsp_aux(ev[6]),
        .agc_noise_left(ev[5]), .agc_noise_right(ev[4]), .rec_dsp_std(ev[3]),
        .rec_dsp_aux(ev[2]), .dc_meas_left(ev[1]), .dc_meas_right(ev[0]),
        .first_interrupt_output(irq));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task check8(input string what, input [7:0] exp, input [7:0] got);
        check_count = check_count + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task report_and_stop;
        $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task settle;
        repeat (5) @(posedge clk);
    endtask

    task set_ev(input [13:0] v);
        @(posedge clk);
        ev <= v;
    endtask

    // Waits a bounded time for a pulse and returns its width, zero if none came.
    task pulse(output [7:0] wid);
        integer n;
        wid = 8'h00;
        n = 0;
        while (irq !== 1'b1 && n < 12)
        begin
            @(posedge clk);
            #1 n = n + 1;
        end
        while (irq === 1'b1 && wid < 8'h28)
        begin
            @(posedge clk);
            #1 wid = wid + 8'h01;
        end
    endtask

    function integer src(input integer cls);
        case (cls)
            7: src = 10;
            6: src = 11;
            5: src = 8;
            4: src = 5;
            3: src = 13;
            2: src = 7;
            default: src = 0;
        endcase
    endfunction

    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == LIMIT)
        begin
            miscompares = miscompares + 1;
            report_and_stop;
        end
    end

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial
    begin
        miscompares = 0;
        check_count = 0;
        cyc = 0;
        arst_n = 1'b0;
        ev = 14'h0000;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (i = 8'h2A; i <= 8'h31; i = i + 1)
        begin
            u_host.rd(i[7:0], d);
            check8("reset value", 8'h00, d);
        end
        u_host.wr(8'h30, 8'h5A);
        u_host.rd(8'h30, d);
        check8("control", 8'h5A, d);
        u_host.wr(8'h30, 8'h00);
        for (i = 0; i < 14; i = i + 1)
        begin
            x = 14'h0001 << i;
            set_ev(x);
            settle;
            u_host.rd(8'h2E, d);
            check8("live two", x[13:6], d);
            u_host.rd(8'h2F, d);
            check8("live three", {1'b0, x[5:0], 1'b0}, d);
            u_host.rd(8'h2C, d);
            check8("sticky two", x[13:6], d);
            u_host.rd(8'h2D, d);
            check8("sticky three", {1'b0, x[5:0], 1'b0}, d);
            set_ev(14'h0000);
            settle;
            u_host.rd2(8'h2C, d, d2);
            check8("sticky two held", x[13:6], d);
            check8("sticky two clear", 8'h00, d2);
            u_host.rd2(8'h2D, d, d2);
            check8("sticky three held", {1'b0, x[5:0], 1'b0}, d);
            check8("sticky three clear", 8'h00, d2);
            u_host.rd(8'h2F, d);
            check8("live three idle", 8'h00, d);
        end
        for (b = 7; b >= 1; b = b - 1)
        begin
            x = 14'h0001 << src(b);
            u_host.wr(8'h30, 8'hFE & ~(8'h01 << b));
            set_ev(x);
            pulse(w);
            check8("masked class", 8'h00, w);
            set_ev(14'h0000);
            settle;
            u_host.rd2(8'h2C, d, d2);
            u_host.rd2(8'h2D, d, d2);
            u_host.wr(8'h30, 8'h01 << b);
            set_ev(x);
            pulse(w);
            check8("single pulse", PULSE, w);
            pulse(w);
            check8("no second pulse", 8'h00, w);
            set_ev(14'h0000);
            settle;
            u_host.rd2(8'h2C, d, d2);
            u_host.rd2(8'h2D, d, d2);
        end
        for (i = 0; i < 3; i = i + 1)
        begin
            u_host.wr(8'h30, 8'h41);
            set_ev(14'h0800);
            set_ev(14'h0000);
            pulse(w);
            check8("train first", PULSE, w);
            pulse(w);
            check8("train second", PULSE, w);
            u_host.rd((i == 0) ? 8'h2A : ((i == 1) ? 8'h2C : 8'h2D), d);
            pulse(w);
            check8("train stopped", 8'h00, w);
            u_host.rd2(8'h2C, d, d2);
        end
        report_and_stop;
    end
endmodule
